// *** ocmp_channel.sv ***
// output compare / pwm channel with ahb-lite register slave
`timescale 1ns/10ps
`include "ocmp_defines.svh"
// Contract
// RULE_01: mode 000 disables the channel
// RULE_02: mode 001 starts low, goes high once
// RULE_03: mode 010 starts high, goes low once
// RULE_04: mode 011 toggles on every match
// RULE_05: mode 100 gives one primary/secondary pulse
// RULE_06: mode 101 gives repeating primary/secondary pulses
// RULE_07: modes 110/111 give edge/centre PWM
// RULE_08: fault comparator chosen by channel number
// RULE_09: hold bit picks fault exit condition
// RULE_10: fault drives output to fault level
// RULE_11: fault may force pin to output
// RULE_12: invert bit inverts the output
// RULE_13: fine field delays falling edge quarters; the code delays it by whole SYS_CLK cycles
// RULE_14: delay moves to rising edge; none in 001
// RULE_15: cascade makes one 32-bit channel
// RULE_16: trigger or sync from selected source
// RULE_17: trigger status set by hardware
// RULE_18: tristate bit floats the pin
// RULE_19: never select own channel as source
// RULE_20: trigger-only inputs never used for sync
// RULE_21: compare event is equality on clock
module ocmp_channel #(
  parameter int CHANNEL = 1
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [31:0] SYNC_SOURCES,
  input  wire logic [2:0]  COMPARATORS,
  output logic             COMPARE_OUT,
  output logic             COMPARE_OE,
  output logic             FAULT_FLAG
);
  import ocmp_pkg::*;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic [15:0] ctrl_one_reg;
  logic [15:0] ctrl_two_reg;
  logic [31:0] primary_reg;
  logic [31:0] secondary_reg;
  logic [31:0] period_reg;
  logic [31:0] timer_reg;
  logic        fault_reg;
  logic        trig_stat_reg;
  logic        wr_pend_reg;
  logic [7:0]  addr_reg;
  logic        run_reg;
  logic        out_reg;
  logic        armed_reg;
  logic        phase_reg;
  logic        up_reg;
  logic [1:0]  sub_reg;
  logic [2:0]  cmp_s1_reg;
  logic [2:0]  cmp_s2_reg;
  logic [2:0]  cmp_s3_reg;
  logic [31:0] src_s1_reg;
  logic [31:0] src_s2_reg;
  logic [31:0] src_s3_reg;

  wire         take    = HSEL && HREADY && HTRANS[1];
  wire         wr_go   = wr_pend_reg;
  wire         cmp_wr  = wr_go && addr_reg == `OFS_CTRL_TWO && HWDATA[`BIT_TRIG_STAT] == 1'b0;
  // read data registered at the address edge, so it stands in the data phase
  wire [7:0]   rd_addr = take ? HADDR[7:0] : addr_reg;
  wire [31:0]  rd_mux  = (rd_addr == `OFS_CTRL_ONE)  ? {16'h0000, ctrl_one_reg} :
                         (rd_addr == `OFS_CTRL_TWO)  ? {16'h0000, ctrl_two_reg[15:7], trig_stat_reg,
                                                        ctrl_two_reg[5:0]} :
                         (rd_addr == `OFS_PRIMARY)   ? primary_reg :
                         (rd_addr == `OFS_SECONDARY) ? secondary_reg :
                         (rd_addr == `OFS_PERIOD)    ? period_reg :
                         (rd_addr == `OFS_STATUS)    ? {30'h00000000, trig_stat_reg, fault_reg} :
                         (rd_addr == `OFS_TIMER)     ? timer_reg : 32'h00000000;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= take && HWRITE;
      addr_reg    <= take ? HADDR[7:0] : addr_reg;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_one_reg  <= `RST_CTRL_ONE;
      ctrl_two_reg  <= `RST_CTRL_TWO;
      primary_reg   <= 32'h00000000;
      secondary_reg <= 32'h00000000;
      period_reg    <= 32'h0000FFFF;
    end else if (wr_go) begin
      if (addr_reg == `OFS_CTRL_ONE)  ctrl_one_reg  <= HWDATA[15:0];
      if (addr_reg == `OFS_CTRL_TWO)  ctrl_two_reg  <= HWDATA[15:0] & 16'hF7FF;
      if (addr_reg == `OFS_PRIMARY)   primary_reg   <= HWDATA;
      if (addr_reg == `OFS_SECONDARY) secondary_reg <= HWDATA;
      if (addr_reg == `OFS_PERIOD)    period_reg    <= HWDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HRDATA    <= rd_mux;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  compare_mode_e compare_mode_select;
  assign compare_mode_select = compare_mode_e'(ctrl_one_reg[2:0]);
  wire          fault_hold_select         = ctrl_two_reg[`BIT_HOLD];
  wire          fault_output_level        = ctrl_two_reg[`BIT_FLT_LEVEL];
  wire          fault_pin_direction_force = ctrl_two_reg[`BIT_FLT_DIR];
  wire          output_invert             = ctrl_two_reg[`BIT_INVERT];
  wire [1:0]    fine_pulse_width          = ctrl_two_reg[10:9];
  wire          cascade_enable            = ctrl_two_reg[`BIT_CASCADE];
  wire          trigger_or_sync_select    = ctrl_two_reg[`BIT_TRIG_SEL];
  wire          output_tristate           = ctrl_two_reg[`BIT_TRISTATE];
  wire [4:0]    trigger_source_select     = ctrl_two_reg[4:0];

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      {cmp_s3_reg, cmp_s2_reg, cmp_s1_reg} <= 9'h000;
      {src_s3_reg, src_s2_reg, src_s1_reg} <= 96'h000000000000000000000000;
    end else begin
      {cmp_s3_reg, cmp_s2_reg, cmp_s1_reg} <= {cmp_s2_reg, cmp_s1_reg, COMPARATORS};
      {src_s3_reg, src_s2_reg, src_s1_reg} <= {src_s2_reg, src_s1_reg, SYNC_SOURCES};
    end
  end

  // comparator index fixed by channel number (see RULE_08)
  localparam int FLT_IDX = (CHANNEL <= 2) ? 0 : (CHANNEL <= 4) ? 1 : 2;
  wire  fault_src = cmp_s2_reg[FLT_IDX] & cmp_s3_reg[FLT_IDX];
  wire  mode_off  = compare_mode_select == MODE_OFF;
  wire  pwm_mode  = compare_mode_select == MODE_PWM_EDGE || compare_mode_select == MODE_PWM_CENTRE;
  // a rising edge of the selected source, once stages two and three agree
  logic src_level_reg;
  wire  src_agree = src_s2_reg[trigger_source_select] == src_s3_reg[trigger_source_select];
  wire  src_rise  = src_agree && src_s3_reg[trigger_source_select] && !src_level_reg;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) src_level_reg <= 1'b0;
    else if (src_agree) src_level_reg <= src_s3_reg[trigger_source_select];
  end

  // ------------------------------------------------------------
  // timer base and matches
  // ------------------------------------------------------------
  ocmp_match_if mi ();
  ocmp_match u_match (.m(mi));
  wire [31:0] wide_mask;
  assign wide_mask    = cascade_enable ? 32'hFFFFFFFF : 32'h0000FFFF;
  assign mi.count     = timer_reg;
  assign mi.primary   = primary_reg;
  assign mi.secondary = secondary_reg;
  assign mi.wide      = cascade_enable; // see RULE_15

  wire at_top       = ((timer_reg ^ period_reg) & wide_mask) == 32'h00000000;
  wire at_bottom    = timer_reg == 32'h00000000;
  wire period_start = compare_mode_select == MODE_PWM_CENTRE ? (at_bottom && !up_reg) : at_top;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      timer_reg <= 32'h00000000;
      up_reg    <= 1'b1;
      run_reg   <= 1'b0;
    end else if (mode_off) begin // see RULE_01
      timer_reg <= 32'h00000000;
      up_reg    <= 1'b1;
      run_reg   <= 1'b0;
    end else begin
      // trigger waits for the source; sync runs and restarts on it (see RULE_16)
      if (trigger_or_sync_select && src_rise) run_reg <= 1'b1;
      else if (!trigger_or_sync_select) run_reg <= 1'b1;
      if (!trigger_or_sync_select && src_rise) timer_reg <= 32'h00000000;
      else if (run_reg || !trigger_or_sync_select) begin
        if (compare_mode_select == MODE_PWM_CENTRE) begin
          if (at_top && up_reg) up_reg <= 1'b0;
          else if (at_bottom && !up_reg) up_reg <= 1'b1;
          timer_reg <= (at_top && up_reg) || (!up_reg && !at_bottom) ? timer_reg - 32'h00000001
                                                                      : timer_reg + 32'h00000001;
        end else begin
          timer_reg <= at_top ? 32'h00000000 : (timer_reg + 32'h00000001) & wide_mask;
        end
      end
    end
  end

  // trigger status, hardware set beats software clear (see RULE_17)
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) trig_stat_reg <= 1'b0;
    else if (trigger_or_sync_select && src_rise && !mode_off) trig_stat_reg <= 1'b1;
    else if (cmp_wr || !trigger_or_sync_select) trig_stat_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // fault handling
  // ------------------------------------------------------------
  wire flt_clear = wr_go && addr_reg == `OFS_STATUS && HWDATA[0];
  // hold: source gone and flag cleared; else source gone at new period (see RULE_09)
  wire flt_exit  = !fault_src && (fault_hold_select ? flt_clear : period_start);
  logic fault_active_reg;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fault_reg        <= 1'b0;
      fault_active_reg <= 1'b0;
    end else begin
      if (pwm_mode && fault_src) fault_reg <= 1'b1;
      else if (flt_clear) fault_reg <= 1'b0;
      if (pwm_mode && fault_src) fault_active_reg <= 1'b1;
      else if (flt_exit || !pwm_mode) fault_active_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // output sequencer
  // ------------------------------------------------------------
  wire hit_p = mi.hit_primary && run_reg;
  wire hit_s = mi.hit_secondary && run_reg;
  logic mode_d_reg;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      out_reg    <= 1'b0;
      armed_reg  <= 1'b0;
      phase_reg  <= 1'b0;
      mode_d_reg <= 1'b1;
    end else begin
      mode_d_reg <= mode_off;
      if (mode_off) begin
        out_reg   <= 1'b0;
        armed_reg <= 1'b1;
        phase_reg <= 1'b0;
      end else if (mode_d_reg) begin
        out_reg   <= compare_mode_select == MODE_SS_LOW; // see RULE_02 see RULE_03
        armed_reg <= 1'b1;
        phase_reg <= 1'b0;
      end else begin
        case (compare_mode_select)
          MODE_SS_HIGH: if (armed_reg && hit_p) begin // see RULE_02
            out_reg   <= 1'b1;
            armed_reg <= 1'b0;
          end
          MODE_SS_LOW: if (armed_reg && hit_p) begin // see RULE_03
            out_reg   <= 1'b0;
            armed_reg <= 1'b0;
          end
          MODE_TOGGLE: if (hit_p) out_reg <= !out_reg; // see RULE_04
          MODE_DUAL_ONE: if (armed_reg) begin // see RULE_05
            if (!phase_reg && hit_p) begin
              out_reg   <= 1'b1;
              phase_reg <= 1'b1;
            end else if (phase_reg && hit_s) begin
              out_reg   <= 1'b0;
              armed_reg <= 1'b0;
            end
          end
          MODE_DUAL_RUN: begin // see RULE_06
            if (!phase_reg && hit_p) begin
              out_reg   <= 1'b1;
              phase_reg <= 1'b1;
            end else if (phase_reg && hit_s) begin
              out_reg   <= 1'b0;
              phase_reg <= 1'b0;
            end
          end
          MODE_PWM_EDGE: begin // see RULE_07
            if (at_top) out_reg <= 1'b1;
            else if (hit_s) out_reg <= 1'b0;
          end
          MODE_PWM_CENTRE: begin // see RULE_07
            if (hit_s) out_reg <= up_reg;
          end
          default: out_reg <= 1'b0;
        endcase
      end
    end
  end

  // whole SYS_CLK cycle steps on the trailing edge (see RULE_13)
  wire       base_out   = out_reg ^ output_invert; // see RULE_12
  wire       use_fine   = compare_mode_select != MODE_SS_HIGH && fine_pulse_width != 2'b00; // see RULE_14
  // inverted output carries the delay on its rising edge (see RULE_14)
  wire       trail_edge = output_invert ? (base_out && !COMPARE_OUT) : (!base_out && COMPARE_OUT);
  logic hold_reg;
  // old level kept from the trailing edge until the last step of the count
  wire       keep_old   = hold_reg ? (sub_reg != 2'b01) : (use_fine && trail_edge);
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sub_reg  <= 2'b00;
      hold_reg <= 1'b0;
    end else if (hold_reg) begin
      sub_reg  <= sub_reg - 2'b01;
      hold_reg <= sub_reg != 2'b01;
    end else if (use_fine && trail_edge) begin
      sub_reg  <= fine_pulse_width;
      hold_reg <= 1'b1;
    end
  end
  wire       lvl_out    = keep_old ? COMPARE_OUT : base_out;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      COMPARE_OUT <= 1'b0;
      COMPARE_OE  <= 1'b0;
      FAULT_FLAG  <= 1'b0;
    end else begin
      COMPARE_OUT <= fault_active_reg ? fault_output_level : lvl_out; // see RULE_10
      COMPARE_OE  <= (fault_active_reg && fault_pin_direction_force) ? 1'b1 // see RULE_11
                     : (!output_tristate && !mode_off); // see RULE_18 see RULE_01
      FAULT_FLAG  <= fault_reg;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_off_quiet: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE_01
    $past(mode_off) && mode_off |-> !COMPARE_OE) else $error("disabled channel drives pin");
  a_tris_float: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE_18
    output_tristate && !fault_active_reg && $stable(ctrl_two_reg) |=> !COMPARE_OE)
    else $error("tristate ignored");
  a_fault_level: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE_10
    fault_active_reg |=> COMPARE_OUT == $past(fault_output_level)) else $error("fault level wrong");
  a_fault_dir: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE_11
    fault_active_reg && fault_pin_direction_force |=> COMPARE_OE) else $error("fault dir not forced");
  a_fault_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE_09
    fault_active_reg && fault_hold_select && pwm_mode && !flt_clear |=> fault_active_reg)
    else $error("held fault released early");
  a_trig_sticky: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE_17
    trig_stat_reg && trigger_or_sync_select && !cmp_wr && !mode_off |=> trig_stat_reg)
    else $error("trigger status lost");
  a_toggle_hit: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE_04
    compare_mode_select == MODE_TOGGLE && !mode_d_reg && hit_p && $stable(ctrl_one_reg)
    |=> out_reg != $past(out_reg)) else $error("toggle missed");
  a_shot_once: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE_02
    compare_mode_select == MODE_SS_HIGH && !armed_reg && !mode_d_reg && $stable(ctrl_one_reg)
    |=> out_reg) else $error("single shot fell back");
endmodule

// *** ocmp_defines.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef OCMP_DEFINES_SVH
`define OCMP_DEFINES_SVH
`define OFS_CTRL_ONE     8'h00
`define OFS_CTRL_TWO     8'h04
`define OFS_PRIMARY      8'h08
`define OFS_SECONDARY    8'h0C
`define OFS_PERIOD       8'h10
`define OFS_STATUS       8'h14
`define OFS_TIMER        8'h18
`define RST_CTRL_ONE     16'h0000
`define RST_CTRL_TWO     16'h000C
`define BIT_HOLD         15
`define BIT_FLT_LEVEL    14
`define BIT_FLT_DIR      13
`define BIT_INVERT       12
`define BIT_CASCADE      8
`define BIT_TRIG_SEL     7
`define BIT_TRIG_STAT    6
`define BIT_TRISTATE     5
`define SUB_STEPS        4
`endif

// *** ocmp_pkg.sv ***
// types shared by the compare channel files
package ocmp_pkg;
  typedef enum logic [2:0] {
    MODE_OFF, MODE_SS_HIGH, MODE_SS_LOW, MODE_TOGGLE,
    MODE_DUAL_ONE, MODE_DUAL_RUN, MODE_PWM_EDGE, MODE_PWM_CENTRE
  } compare_mode_e;
  typedef logic [15:0] half_t;
endpackage

// *** ocmp_match_if.sv ***
// carries timer count and compare values to the match unit
`timescale 1ns/10ps
interface ocmp_match_if;
  logic [31:0] count;
  logic [31:0] primary;
  logic [31:0] secondary;
  logic        wide;
  logic        hit_primary;
  logic        hit_secondary;
  modport core  (output count, primary, secondary, wide, input hit_primary, hit_secondary);
  modport match (input count, primary, secondary, wide, output hit_primary, hit_secondary);
endinterface

// *** ocmp_match.sv ***
// equality comparators for the primary and secondary values
`timescale 1ns/10ps
module ocmp_match (
  ocmp_match_if.match m
);
  wire [31:0] mask;
  assign mask = m.wide ? 32'hFFFFFFFF : 32'h0000FFFF;
  // compare event is the cycle of equality (see RULE_21) (see RULE_15)
  assign m.hit_primary   = ((m.count ^ m.primary) & mask) == 32'h00000000;
  assign m.hit_secondary = ((m.count ^ m.secondary) & mask) == 32'h00000000;
endmodule

// *** ocmp_load.sv ***
// external load model watching the compare output pin
`timescale 1ns/10ps
module ocmp_load (
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  input  wire logic        drive_val,
  input  wire logic        drive_en,
  input  wire logic        clear_count,
  output logic             pin_level,
  output logic      [15:0] toggle_count,
  output logic      [15:0] high_count
);
  logic last_reg;
  logic prev_reg;

  // released pin has no keeper: show the inverse of the last driven level
  assign pin_level = drive_en ? drive_val : ~last_reg;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      last_reg     <= 1'b0;
      prev_reg     <= 1'b0;
      toggle_count <= 16'h0000;
      high_count   <= 16'h0000;
    end else begin
      prev_reg <= pin_level;
      if (drive_en) begin
        last_reg <= drive_val;
      end
      if (clear_count) begin
        toggle_count <= 16'h0000;
        high_count   <= 16'h0000;
      end else if (drive_en) begin
        toggle_count <= toggle_count + {15'h0000, pin_level ^ prev_reg};
        high_count   <= high_count + {15'h0000, pin_level};
      end
    end
  end
endmodule

// *** output_compare_pwm_channel_test.sv ***
// self-checking bench for the compare channel
`timescale 1ns/10ps
`include "ocmp_defines.svh"
module output_compare_pwm_channel_test;
  import ocmp_pkg::*;
  localparam int PERIOD = 31;
  localparam int WIN    = 4 * (PERIOD + 1) + 4;
  typedef struct packed {
    logic [2:0] mode; logic ci; logic init; logic cf; logic fin; logic [7:0] tmin; logic [7:0] tmax;
  } row_s;
  logic sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clear_count = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, sync_sources = 32'h0, rd, t0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010, comparators = 3'b000;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, compare_out, compare_oe, fault_flag, pin_level;
  logic [15:0] toggle_count, high_count, h0, h1;
  int err_total = 0, n_compared = 0, cycles = 0;
  row_s rows [8] = '{'{3'd0, 1'b1, 1'b0, 1'b1, 1'b0, 8'd0, 8'd0}, '{3'd1, 1'b1, 1'b0, 1'b1, 1'b1, 8'd1, 8'd1},
                     '{3'd2, 1'b1, 1'b1, 1'b1, 1'b0, 8'd1, 8'd1}, '{3'd3, 1'b0, 1'b0, 1'b0, 1'b0, 8'd3, 8'd5},
                     '{3'd4, 1'b1, 1'b0, 1'b1, 1'b0, 8'd2, 8'd2}, '{3'd5, 1'b1, 1'b0, 1'b0, 1'b0, 8'd7, 8'd9},
                     '{3'd6, 1'b0, 1'b0, 1'b0, 1'b0, 8'd7, 8'd9}, '{3'd7, 1'b0, 1'b0, 1'b0, 1'b0, 8'd3, 8'd9}};

  always #5 sys_clk = ~sys_clk;

  ocmp_channel #(.CHANNEL(1)) dut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .SYNC_SOURCES(sync_sources), .COMPARATORS(comparators), .COMPARE_OUT(compare_out),
    .COMPARE_OE(compare_oe), .FAULT_FLAG(fault_flag)
  );

  ocmp_load load (
    .SYS_CLK(sys_clk), .RSTN(rstn), .drive_val(compare_out), .drive_en(compare_oe),
    .clear_count(clear_count), .pin_level(pin_level), .toggle_count(toggle_count), .high_count(high_count)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // single word transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic run_row(input row_s r, input logic inv);
    xfer(1'b1, `OFS_CTRL_ONE, 32'h0, rd);
    xfer(1'b1, `OFS_PRIMARY, 32'hFFFF, rd);
    xfer(1'b1, `OFS_SECONDARY, 32'hFFFF, rd);
    xfer(1'b1, `OFS_CTRL_ONE, {29'h0, r.mode}, rd);
    wait_cyc(3);
    @(negedge sys_clk);
    if (r.ci) check(compare_out, r.init ^ inv, "initial level");
    @(posedge sys_clk);
    clear_count <= 1'b1;
    @(posedge sys_clk);
    clear_count <= 1'b0;
    xfer(1'b1, `OFS_PRIMARY, 32'h10, rd);
    xfer(1'b1, `OFS_SECONDARY, 32'h18, rd);
    wait_cyc(WIN);
    @(negedge sys_clk);
    if (r.cf) check(compare_out, r.fin ^ inv, "final level");
    check(toggle_count >= r.tmin && toggle_count <= r.tmax, 1, "edge count");
    @(posedge sys_clk);
    $display("test mode %0d invert %0d done", r.mode, inv);
  endtask

  task automatic measure(output logic [15:0] h);
    clear_count <= 1'b1;
    @(posedge sys_clk);
    clear_count <= 1'b0;
    wait_cyc(WIN);
    h = high_count;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      err_total++;
      complete_run();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    wait_cyc(8);
    rstn <= 1'b1;
    @(posedge sys_clk);
    xfer(1'b0, `OFS_CTRL_ONE, 32'h0, rd);
    check(rd, 32'h0, "control one reset");
    xfer(1'b0, `OFS_CTRL_TWO, 32'h0, rd);
    check(rd, 32'h000C, "control two reset");
    xfer(1'b0, `OFS_PERIOD, 32'h0, rd);
    check(rd, 32'hFFFF, "period reset");
    xfer(1'b0, 8'h1C, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    xfer(1'b1, `OFS_CTRL_TWO, 32'h010C, rd);
    xfer(1'b0, `OFS_CTRL_TWO, 32'h0, rd);
    check(rd, 32'h010C, "cascade readback");
    xfer(1'b1, `OFS_CTRL_TWO, 32'h000C, rd);
    xfer(1'b1, `OFS_PERIOD, PERIOD, rd);
    $display("test registers done");
    foreach (rows[i]) run_row(rows[i], 1'b0);
    xfer(1'b1, `OFS_CTRL_TWO, 32'h100C, rd);
    run_row(rows[1], 1'b1);
    xfer(1'b1, `OFS_CTRL_TWO, 32'h000C, rd);
    run_row(rows[6], 1'b0);
    measure(h0);
    xfer(1'b1, `OFS_CTRL_TWO, 32'h060C, rd);
    measure(h1);
    check((h1 - h0) >= 16'd8 && (h1 - h0) <= 16'd16, 1, "fine width stretch");
    $display("test fine width done");
    xfer(1'b1, `OFS_CTRL_TWO, 32'h002C, rd);
    wait_cyc(4);
    check(compare_oe, 1'b0, "tristate enable");
    xfer(1'b1, `OFS_CTRL_TWO, 32'hE02C, rd);
    comparators <= 3'b110;
    wait_cyc(8);
    check(fault_flag, 1'b0, "foreign comparator");
    comparators <= 3'b001;
    wait_cyc(8);
    check({compare_out, compare_oe, fault_flag}, 3'b111, "fault drive");
    comparators <= 3'b000;
    wait_cyc(WIN);
    check({compare_out, fault_flag}, 2'b11, "fault held");
    xfer(1'b1, `OFS_STATUS, 32'h1, rd);
    wait_cyc(WIN);
    check({compare_oe, fault_flag}, 2'b00, "fault released");
    $display("test fault done");
    xfer(1'b1, `OFS_CTRL_ONE, 32'h0, rd);
    xfer(1'b1, `OFS_CTRL_TWO, 32'h0083, rd);
    xfer(1'b1, `OFS_CTRL_ONE, 32'h6, rd);
    xfer(1'b0, `OFS_CTRL_TWO, 32'h0, rd);
    check(rd[6], 1'b0, "status before trigger");
    xfer(1'b0, `OFS_TIMER, 32'h0, t0);
    wait_cyc(5);
    xfer(1'b0, `OFS_TIMER, 32'h0, rd);
    check(rd, t0, "timer held awaiting trigger");
    sync_sources <= 32'h8;
    wait_cyc(8);
    xfer(1'b0, `OFS_CTRL_TWO, 32'h0, rd);
    check(rd[6], 1'b1, "status after trigger");
    $display("test trigger done");
    complete_run();
  end
endmodule
